// ===== src/spi_cmd_pkg.sv
// shared opcodes, phase lengths, reset values and frame types of the register command decoder
package spi_cmd_pkg;

	// ------------------------------------------------------------
	// command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] READ_IDENTIFICATION_CMD = 8'h9F;
	localparam logic [7:0] READ_DISCOVERY_PARAMETERS_CMD = 8'h5A;
	localparam logic [7:0] READ_STATUS_CMD = 8'h05;
	localparam logic [7:0] READ_CONFIG_CMD = 8'h15;
	localparam logic [7:0] WRITE_STATUS_CONFIG_CMD = 8'h01;
	localparam logic [7:0] READ_CONFIG_TWO_CMD = 8'h71;
	localparam logic [7:0] WRITE_CONFIG_TWO_CMD = 8'h72;
	localparam logic [7:0] READ_BOOT_VECTOR_CMD = 8'h16;
	localparam logic [7:0] WRITE_BOOT_VECTOR_CMD = 8'h17;
	localparam logic [7:0] ERASE_BOOT_VECTOR_CMD = 8'h18;
	localparam logic [7:0] READ_SECURE_REG_CMD = 8'h2B;
	localparam logic [7:0] SET_LOCKDOWN_CMD = 8'h2F;
	localparam logic [7:0] WRITE_LOCK_REG_CMD = 8'h2C;
	localparam logic [7:0] READ_LOCK_REG_CMD = 8'h2D;
	localparam logic [7:0] PROGRAM_PERSISTENT_BIT_CMD = 8'hE3;
	localparam logic [7:0] ERASE_PERSISTENT_BITS_CMD = 8'hE4;
	localparam logic [7:0] READ_PERSISTENT_BIT_CMD = 8'hE2;
	localparam logic [7:0] WRITE_DYNAMIC_BIT_CMD = 8'hE1;
	localparam logic [7:0] READ_DYNAMIC_BIT_CMD = 8'hE0;
	localparam logic [7:0] PROTECT_SELECT_CMD = 8'h68;
	localparam logic [7:0] GANG_LOCK_CMD = 8'h7E;
	localparam logic [7:0] GANG_UNLOCK_CMD = 8'h98;
	localparam logic [7:0] READ_PASSWORD_CMD = 8'h27;
	localparam logic [7:0] WRITE_PASSWORD_CMD = 8'h28;
	localparam logic [7:0] PASSWORD_UNLOCK_CMD = 8'h29;
	localparam logic [7:0] RESET_ARM_CMD = 8'h66;
	localparam logic [7:0] MEMORY_RESET_CMD = 8'h99;

	// ------------------------------------------------------------
	// phase lengths in serial clock cycles
	// ------------------------------------------------------------
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] OPCODE_CYCLES = 12'h008;
	localparam logic [5:0] ADDR3_CYCLES = 6'h18;
	localparam logic [5:0] ADDR4_CYCLES = 6'h20;
	localparam logic [3:0] PASS_DUMMY_CYCLES = 4'h8;
	localparam logic [5:0] PASS_DATA_CYCLES = 6'h08;
	localparam logic [5:0] BYTE_CYCLES = 6'h08;
	localparam logic [5:0] TWO_BYTE_CYCLES = 6'h10;
	localparam logic [5:0] WORD_CYCLES = 6'h20;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] CONFIG_TWO_RST = 8'h00;
	localparam logic [31:0] BOOT_VECTOR_RST = 32'hFFFF_FFFF;
	localparam logic [7:0] SECURE_RST = 8'h00;
	localparam logic [7:0] LOCK_REG_RST = 8'h00;
	localparam logic [7:0] PASSWORD_RST = 8'hFF;
	localparam int LOCKDOWN_BIT = 1;
	localparam logic [7:0] BIT_SET_BYTE = 8'hFF;
	localparam logic [7:0] BIT_CLEAR_BYTE = 8'h00;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic known;
		logic rd;
		logic [5:0] abits;
		logic [3:0] dummy;
		logic [5:0] wmin;
		logic [5:0] wmax;
	} cmd_info_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [31:0] addr;
		logic [31:0] data;
		logic [CNT_W-1:0] bits;
	} frame_type;

	// phase layout of each opcode; unknown codes come back with known low
	function automatic cmd_info_type cmd_info(input logic [7:0] op);
		cmd_info_type ci;
		ci = '0;
		ci.known = 1'b1;
		case (op)
			READ_IDENTIFICATION_CMD, READ_STATUS_CMD, READ_CONFIG_CMD,
			READ_BOOT_VECTOR_CMD, READ_SECURE_REG_CMD, READ_LOCK_REG_CMD: ci.rd = 1'b1;
			READ_DISCOVERY_PARAMETERS_CMD: begin
				ci.rd = 1'b1;
				ci.abits = ADDR3_CYCLES;
			end
			READ_CONFIG_TWO_CMD, READ_PERSISTENT_BIT_CMD, READ_DYNAMIC_BIT_CMD: begin
				ci.rd = 1'b1;
				ci.abits = ADDR4_CYCLES;
			end
			READ_PASSWORD_CMD: begin
				ci.rd = 1'b1;
				ci.abits = ADDR4_CYCLES;
				ci.dummy = PASS_DUMMY_CYCLES;
			end
			WRITE_STATUS_CONFIG_CMD: begin
				ci.wmin = BYTE_CYCLES;
				ci.wmax = TWO_BYTE_CYCLES;
			end
			WRITE_CONFIG_TWO_CMD, WRITE_DYNAMIC_BIT_CMD: begin
				ci.abits = ADDR4_CYCLES;
				ci.wmin = BYTE_CYCLES;
				ci.wmax = BYTE_CYCLES;
			end
			WRITE_BOOT_VECTOR_CMD: begin
				ci.wmin = WORD_CYCLES;
				ci.wmax = WORD_CYCLES;
			end
			WRITE_LOCK_REG_CMD: begin
				ci.wmin = BYTE_CYCLES;
				ci.wmax = BYTE_CYCLES;
			end
			PROGRAM_PERSISTENT_BIT_CMD: ci.abits = ADDR4_CYCLES;
			WRITE_PASSWORD_CMD, PASSWORD_UNLOCK_CMD: begin
				ci.abits = ADDR4_CYCLES;
				ci.wmin = PASS_DATA_CYCLES;
				ci.wmax = PASS_DATA_CYCLES;
			end
			ERASE_BOOT_VECTOR_CMD, SET_LOCKDOWN_CMD, ERASE_PERSISTENT_BITS_CMD, PROTECT_SELECT_CMD,
			GANG_LOCK_CMD, GANG_UNLOCK_CMD, RESET_ARM_CMD, MEMORY_RESET_CMD: ci.known = 1'b1;
			default: ci.known = 1'b0;
		endcase
		return ci;
	endfunction

endpackage

// ===== src/sync_two_flop.sv
// two flip-flop synchroniser with a constant value under asynchronous reset
`timescale 1ns/100ps
module sync_two_flop #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// level in and out
	input wire logic d_i,
	output logic q_o
);

	logic meta_r;
	logic hold_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= RST_VAL;
			hold_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			hold_r <= meta_r;
		end
	end

	assign q_o = hold_r;

endmodule // sync_two_flop

// ===== src/spi_register_command_decoder.sv
// serial register command decoder: link capture and read shifter on the serial clock, register core on clk_i
`timescale 1ns/100ps
module spi_register_command_decoder
	import spi_cmd_pkg::*;
#(
	parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h5A3C, // arbitrary value
	parameter int NUM_BLOCKS = 16,
	parameter int BLOCK_SHIFT = 16,
	parameter int CFG2_DEPTH = 4,
	parameter logic [127:0] DISC_IMAGE = 128'h0
) (
	// system
	input wire logic clk_i,
	input wire logic arst_n_i,
	// serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	// register state
	output logic [7:0] status_o,
	output logic [7:0] config_o,
	output logic [CFG2_DEPTH*8-1:0] config_two_o,
	output logic [31:0] boot_vector_o,
	output logic [7:0] secure_o,
	output logic [7:0] lock_reg_o,
	output logic [NUM_BLOCKS-1:0] persistent_block_bit_o,
	output logic [NUM_BLOCKS-1:0] dynamic_block_bit_o,
	output logic block_mode_o,
	output logic password_ok_o,
	// command events
	output logic cmd_done_o,
	output logic cmd_reject_o,
	output logic mem_reset_o
);

	localparam int IDX_W = $clog2(NUM_BLOCKS);
	localparam int C2_W = $clog2(CFG2_DEPTH);

	function automatic logic [IDX_W-1:0] blk_idx(input logic [31:0] a);
		return a[BLOCK_SHIFT +: IDX_W];
	endfunction

	function automatic logic [C2_W-1:0] c2_idx(input logic [31:0] a);
		return a[C2_W-1:0];
	endfunction

	// register core state, read quasi-statically by the shifter
	logic [7:0] status_r;
	logic [7:0] config_r;
	logic [7:0] cfg2_r [CFG2_DEPTH];
	logic [31:0] boot_r;
	logic [7:0] sec_r;
	logic [7:0] lock_r;
	logic [NUM_BLOCKS-1:0] pbit_r;
	logic [NUM_BLOCKS-1:0] dbit_r;
	logic [7:0] password_r;

	// ------------------------------------------------------------
	// link side: frame capture on the serial clock
	// ------------------------------------------------------------
	logic in_frame_r;
	logic rd_phase_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [7:0] op_r;
	logic [31:0] addr_r;
	logic [31:0] data_r;
	logic [7:0] tx_r;
	logic miso_r;
	logic oe_r;
	logic [7:0] cur_op;
	logic [31:0] cur_addr;
	cmd_info_type info;
	logic [CNT_W-1:0] ds;
	logic [CNT_W-1:0] rel;
	logic [CNT_W-4:0] bi;
	logic addr_ph;
	logic tx_load;
	logic [7:0] rd_byte;
	logic [3:0] disc_idx;

	always_comb begin
		cnt_nxt = !in_frame_r ? CNT_W'(1) : (&cnt_r) ? cnt_r : cnt_r + 1'b1;
		cur_op = (cnt_nxt <= OPCODE_CYCLES) ? {op_r[6:0], mosi_i} : op_r;
		info = cmd_info(cur_op);
		addr_ph = (cnt_nxt > OPCODE_CYCLES) && (cnt_nxt <= OPCODE_CYCLES + CNT_W'(info.abits));
		cur_addr = addr_ph ? {addr_r[30:0], mosi_i} : addr_r;
		ds = OPCODE_CYCLES + CNT_W'(info.abits) + CNT_W'(info.dummy);
		rel = cnt_nxt - ds;
		bi = rel[CNT_W-1:3];
		tx_load = info.rd && (cnt_nxt >= ds) && (rel[2:0] == 3'h0);
	end

	// chip select high ends the frame without needing a trailing serial clock edge
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			in_frame_r <= 1'b0;
			rd_phase_r <= 1'b0;
		end else begin
			in_frame_r <= 1'b1;
			rd_phase_r <= info.rd && (cnt_nxt >= ds);
		end
	end

	// capture registers keep their value while the serial clock stands still after the frame
	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= '0;
			op_r <= 8'h00;
			addr_r <= 32'h0000_0000;
			data_r <= 32'h0000_0000;
		end else begin
			cnt_r <= cnt_nxt;
			op_r <= cur_op;
			addr_r <= cur_addr;
			if (cnt_nxt > ds) begin
				data_r <= {data_r[30:0], mosi_i};
			end
		end
	end

	always_comb begin
		disc_idx = 4'(cur_addr[3:0] + bi[3:0]);
		rd_byte = 8'h00;
		case (cur_op)
			READ_IDENTIFICATION_CMD: begin
				if (bi == '0) begin
					rd_byte = MFR_CODE;
				end else if (bi == (CNT_W-3)'(1)) begin
					rd_byte = DEV_CODE[15:8];
				end else if (bi == (CNT_W-3)'(2)) begin
					rd_byte = DEV_CODE[7:0];
				end
			end
			READ_STATUS_CMD: rd_byte = status_r;
			READ_CONFIG_CMD: rd_byte = (bi == '0) ? config_r : 8'h00;
			READ_DISCOVERY_PARAMETERS_CMD: rd_byte = DISC_IMAGE[{4'hF - disc_idx, 3'h0} +: 8];
			READ_CONFIG_TWO_CMD: rd_byte = (bi == '0) ? cfg2_r[c2_idx(cur_addr)] : 8'h00;
			READ_BOOT_VECTOR_CMD: begin
				if (bi < (CNT_W-3)'(4)) begin
					rd_byte = boot_r[{2'h3 - bi[1:0], 3'h0} +: 8];
				end
			end
			READ_SECURE_REG_CMD: rd_byte = (bi == '0) ? sec_r : 8'h00;
			READ_LOCK_REG_CMD: rd_byte = (bi == '0) ? lock_r : 8'h00;
			READ_PERSISTENT_BIT_CMD: begin
				if (bi == '0) begin
					rd_byte = pbit_r[blk_idx(cur_addr)] ? BIT_SET_BYTE : BIT_CLEAR_BYTE;
				end
			end
			READ_DYNAMIC_BIT_CMD: begin
				if (bi == '0) begin
					rd_byte = dbit_r[blk_idx(cur_addr)] ? BIT_SET_BYTE : BIT_CLEAR_BYTE;
				end
			end
			READ_PASSWORD_CMD: rd_byte = (bi == '0) ? password_r : 8'h00;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge sclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_r <= 8'h00;
		end else if (tx_load) begin
			tx_r <= rd_byte;
		end else begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// launch on the falling edge so the host samples a settled bit on the rising edge
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			miso_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			miso_r <= tx_r[7];
			oe_r <= rd_phase_r;
		end
	end

	assign miso_o = miso_r;
	assign miso_oe_o = oe_r;

	// ------------------------------------------------------------
	// core side: frame hand-over on clk_i
	// ------------------------------------------------------------
	logic rst_n;
	logic cs_s;
	logic cs_prev_r;
	logic frame_end;
	frame_type fr;
	cmd_info_type ci;
	logic [CNT_W-1:0] ds_c;
	logic [CNT_W-1:0] dbits;
	logic exec;
	logic valid;
	logic ok;
	logic addr_zero;

	sync_two_flop #(.RST_VAL(1'b0)) u_rst_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i(1'b1),
		.q_o(rst_n)
	);

	sync_two_flop #(.RST_VAL(1'b1)) u_cs_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.d_i(cs_n_i),
		.q_o(cs_s)
	);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_r <= 1'b1;
		end else begin
			cs_prev_r <= cs_s;
		end
	end

	// the capture registers are stable once chip select has been seen high
	assign fr.opcode = op_r;
	assign fr.addr = addr_r;
	assign fr.data = data_r;
	assign fr.bits = cnt_r;

	always_comb begin
		frame_end = cs_s && !cs_prev_r;
		ci = cmd_info(fr.opcode);
		ds_c = OPCODE_CYCLES + CNT_W'(ci.abits) + CNT_W'(ci.dummy);
		dbits = fr.bits - ds_c;
		exec = frame_end && (fr.bits >= OPCODE_CYCLES);
		valid = ci.known && (fr.bits >= ds_c) && (ci.rd || ((dbits >= CNT_W'(ci.wmin)) &&
			(dbits <= CNT_W'(ci.wmax)) && (dbits[2:0] == 3'h0)));
		ok = exec && valid;
		addr_zero = (fr.addr == 32'h0000_0000);
	end

	// ------------------------------------------------------------
	// status, configuration and configuration two
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= STATUS_RST;
			config_r <= CONFIG_RST;
		end else if (ok && fr.opcode == WRITE_STATUS_CONFIG_CMD) begin
			if (dbits == CNT_W'(TWO_BYTE_CYCLES)) begin
				status_r <= fr.data[15:8];
				config_r <= fr.data[7:0];
			end else begin
				status_r <= fr.data[7:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CFG2_DEPTH; i++) begin
				cfg2_r[i] <= CONFIG_TWO_RST;
			end
		end else if (ok && fr.opcode == WRITE_CONFIG_TWO_CMD) begin
			cfg2_r[c2_idx(fr.addr)] <= fr.data[7:0];
		end
	end

	// ------------------------------------------------------------
	// boot vector, security and lock registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			boot_r <= BOOT_VECTOR_RST;
		end else if (ok && fr.opcode == WRITE_BOOT_VECTOR_CMD) begin
			boot_r <= fr.data;
		end else if (ok && fr.opcode == ERASE_BOOT_VECTOR_CMD) begin
			boot_r <= BOOT_VECTOR_RST;
		end
	end

	// lockdown only ever sets; nothing but reset in this block clears it again
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sec_r <= SECURE_RST;
		end else if (ok && fr.opcode == SET_LOCKDOWN_CMD) begin
			sec_r[LOCKDOWN_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lock_r <= LOCK_REG_RST;
		end else if (ok && fr.opcode == WRITE_LOCK_REG_CMD) begin
			lock_r <= fr.data[7:0];
		end
	end

	// ------------------------------------------------------------
	// block protection
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pbit_r <= '0;
		end else if (ok && fr.opcode == PROGRAM_PERSISTENT_BIT_CMD) begin
			pbit_r[blk_idx(fr.addr)] <= 1'b1;
		end else if (ok && fr.opcode == ERASE_PERSISTENT_BITS_CMD) begin
			pbit_r <= '0;
		end
	end

	// dynamic bits are volatile, so a memory reset clears them too
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dbit_r <= '0;
		end else if (ok && fr.opcode == WRITE_DYNAMIC_BIT_CMD) begin
			dbit_r[blk_idx(fr.addr)] <= |fr.data[7:0];
		end else if (ok && fr.opcode == GANG_LOCK_CMD) begin
			dbit_r <= '1;
		end else if (ok && fr.opcode == GANG_UNLOCK_CMD) begin
			dbit_r <= '0;
		end else if (mem_reset_o) begin
			dbit_r <= '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			block_mode_o <= 1'b0;
		end else if (ok && fr.opcode == PROTECT_SELECT_CMD) begin
			block_mode_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// password
	// ------------------------------------------------------------
	// frames with a non-zero address are dropped rather than guessed at
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			password_r <= PASSWORD_RST;
		end else if (ok && addr_zero && fr.opcode == WRITE_PASSWORD_CMD) begin
			password_r <= fr.data[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			password_ok_o <= 1'b0;
		end else if (ok && addr_zero && fr.opcode == PASSWORD_UNLOCK_CMD) begin
			password_ok_o <= (fr.data[7:0] == password_r);
		end else if (mem_reset_o) begin
			password_ok_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// reset sequencing and command events
	// ------------------------------------------------------------
	logic arm_r;

	// any completed opcode other than the arm itself disarms, even an unknown one
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			arm_r <= 1'b0;
		end else if (exec) begin
			arm_r <= ok && (fr.opcode == RESET_ARM_CMD);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_reset_o <= 1'b0;
		end else begin
			mem_reset_o <= ok && arm_r && (fr.opcode == MEMORY_RESET_CMD);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_done_o <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			cmd_done_o <= ok;
			cmd_reject_o <= exec && !valid;
		end
	end

	// ------------------------------------------------------------
	// state outputs
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < CFG2_DEPTH; i++) begin
			config_two_o[i*8 +: 8] = cfg2_r[i];
		end
	end

	assign status_o = status_r;
	assign config_o = config_r;
	assign boot_vector_o = boot_r;
	assign secure_o = sec_r;
	assign lock_reg_o = lock_r;
	assign persistent_block_bit_o = pbit_r;
	assign dynamic_block_bit_o = dbit_r;

endmodule // spi_register_command_decoder

// ===== bench/spi_cmd_chk.sv
// port checker for the register command decoder
`timescale 1ns/100ps
module spi_cmd_chk
	import spi_cmd_pkg::*;
#(
	parameter int NUM_BLOCKS = 16
) (
	// system
	input wire logic clk_i,
	input wire logic arst_n_i,
	// serial link
	input wire logic cs_n_i,
	input wire logic miso_o,
	input wire logic miso_oe_o,
	// register state
	input wire logic [7:0] status_o,
	input wire logic [7:0] config_o,
	input wire logic [31:0] boot_vector_o,
	input wire logic [7:0] secure_o,
	input wire logic [7:0] lock_reg_o,
	input wire logic [NUM_BLOCKS-1:0] dynamic_block_bit_o,
	input wire logic block_mode_o,
	input wire logic password_ok_o,
	// command events
	input wire logic cmd_done_o,
	input wire logic cmd_reject_o,
	input wire logic mem_reset_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence lone_pulse_s;
		!mem_reset_o ##1 !mem_reset_o;
	endsequence
	sequence cleared_s;
		dynamic_block_bit_o == '0 && !password_ok_o;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	frame_closed_a: assert property ((cmd_done_o || cmd_reject_o) |-> cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2))
		else $error("frame executed while chip select low");
	miso_idle_a: assert property (cs_n_i |-> !miso_oe_o && !miso_o)
		else $error("miso driven outside a frame");
	one_kind_a: assert property (!(cmd_done_o && cmd_reject_o))
		else $error("frame both executed and refused");
	done_pulse_a: assert property (cmd_done_o |=> !cmd_done_o)
		else $error("done pulse longer than one cycle");
	reg_cause_a: assert property ($changed({status_o, config_o, lock_reg_o, boot_vector_o}) |-> cmd_done_o)
		else $error("register changed without an executed frame");
	reject_keep_a: assert property (cmd_reject_o |-> $stable({status_o, config_o, lock_reg_o, secure_o}))
		else $error("refused frame changed a register");
	lockdown_keep_a: assert property (secure_o[LOCKDOWN_BIT] |=> secure_o[LOCKDOWN_BIT])
		else $error("lockdown bit cleared");
	mode_cause_a: assert property ($rose(block_mode_o) |-> cmd_done_o)
		else $error("block mode entered without a frame");
	rst_pulse_a: assert property (mem_reset_o |=> lone_pulse_s)
		else $error("memory reset pulse repeated");
	rst_clear_a: assert property (mem_reset_o |-> ##[0:2] cleared_s)
		else $error("memory reset left protection state");
endmodule // spi_cmd_chk

bind spi_register_command_decoder spi_cmd_chk #(.NUM_BLOCKS(NUM_BLOCKS)) chk (
	.clk_i, .arst_n_i, .cs_n_i, .miso_o, .miso_oe_o, .status_o, .config_o, .boot_vector_o,
	.secure_o, .lock_reg_o, .dynamic_block_bit_o, .block_mode_o, .password_ok_o,
	.cmd_done_o, .cmd_reject_o, .mem_reset_o);

// ===== bench/spi_host_model.sv
// serial host model: chip select, stopped-when-idle clock, msb-first data
`timescale 1ns/100ps
module spi_host_model (
	// serial link
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	logic [127:0] rx;
	int half = 3;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// the 1.3 ns offset keeps link edges off the core clock edges
	task automatic frame(input int n, input logic [127:0] tx);
		#1.3;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = tx[i];
			#half;
			sclk_o = 1'b1;
			rx = {rx[126:0], miso_i};
			#half;
			sclk_o = 1'b0;
		end
		#half;
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#30;
	endtask
endmodule // spi_host_model

// ===== bench/spi_register_command_decoder_tb_top.sv
// self-checking bench for the register command decoder
`timescale 1ns/100ps
module spi_register_command_decoder_tb_top import spi_cmd_pkg::*;;
	localparam logic [7:0] MFR = 8'h3C; // arbitrary value
	localparam logic [15:0] DEV = 16'hC35A; // arbitrary value
	localparam logic [127:0] DISC = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
	logic clk_i, arst_n_i, sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_o, block_mode_o, password_ok_o;
	logic cmd_done_o, cmd_reject_o, mem_reset_o;
	logic [7:0] status_o, config_o, secure_o, lock_reg_o;
	logic [31:0] config_two_o, boot_vector_o;
	logic [15:0] persistent_block_bit_o, dynamic_block_bit_o;
	int fails = 0;
	int checks_done = 0;
	// four-state counters so that an unknown pulse cannot pass as a zero count
	logic [31:0] nd, nr, nm;
	spi_register_command_decoder #(.MFR_CODE(MFR), .DEV_CODE(DEV), .DISC_IMAGE(DISC)) DUT (
		.clk_i, .arst_n_i, .sclk_i, .cs_n_i, .mosi_i, .miso_o, .miso_oe_o, .status_o, .config_o,
		.config_two_o, .boot_vector_o, .secure_o, .lock_reg_o, .persistent_block_bit_o,
		.dynamic_block_bit_o, .block_mode_o, .password_ok_o, .cmd_done_o, .cmd_reject_o, .mem_reset_o);
	spi_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .miso_i(miso_o));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		nd += cmd_done_o;
		nr += cmd_reject_o;
		nm += mem_reset_o;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one frame of n bits, then the executed and refused counts; d below zero skips one
	task automatic x(input int n, input logic [127:0] v, input int d, input int r);
		@(posedge clk_i);
		#1;
		nd = 0;
		nr = 0;
		host.frame(n, v);
		if (d >= 0) cmp(nd, d);
		cmp(nr, r);
	endtask
	task automatic rst;
		@(posedge clk_i);
		#1 arst_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		cmp({status_o, config_o, secure_o, lock_reg_o, block_mode_o}, 33'h0);
		cmp(boot_vector_o, BOOT_VECTOR_RST);
		$display("reset values done");
	endtask
	task automatic t_ident;
		x(32, {READ_IDENTIFICATION_CMD, 24'h0}, 1, 0);
		cmp(host.rx[23:0], {MFR, DEV});
		x(48, {READ_DISCOVERY_PARAMETERS_CMD, 24'h3, 16'h0}, 1, 0);
		cmp(host.rx[15:0], 16'h3344);
		$display("identification done");
	endtask
	task automatic t_status;
		x(24, {WRITE_STATUS_CONFIG_CMD, 16'h5CA3}, 1, 0);
		cmp({status_o, config_o}, 16'h5CA3);
		x(24, {READ_STATUS_CMD, 16'h0}, 1, 0);
		cmp(host.rx[15:0], 16'h5C5C);
		x(16, {READ_CONFIG_CMD, 8'h0}, 1, 0);
		cmp(host.rx[7:0], 8'hA3);
		x(16, {WRITE_STATUS_CONFIG_CMD, 8'h11}, 1, 0);
		cmp({status_o, config_o}, 16'h11A3);
		x(32, {WRITE_STATUS_CONFIG_CMD, 24'h0}, 0, 1);
		$display("status done");
	endtask
	task automatic t_regs;
		x(16, {WRITE_LOCK_REG_CMD, 8'h96}, 1, 0);
		cmp(lock_reg_o, 8'h96);
		x(16, {READ_LOCK_REG_CMD, 8'h0}, 1, 0);
		cmp(host.rx[7:0], 8'h96);
		x(24, {WRITE_LOCK_REG_CMD, 16'h0}, 0, 1);
		x(40, {WRITE_BOOT_VECTOR_CMD, 32'h1234_5678}, 1, 0);
		x(40, {READ_BOOT_VECTOR_CMD, 32'h0}, 1, 0);
		cmp(host.rx[31:0], 32'h1234_5678);
		x(16, {READ_BOOT_VECTOR_CMD, 8'h0}, 1, 0);
		cmp(host.rx[7:0], 8'h12);
		x(8, ERASE_BOOT_VECTOR_CMD, 1, 0);
		cmp(boot_vector_o, BOOT_VECTOR_RST);
		x(8, SET_LOCKDOWN_CMD, 1, 0);
		x(16, {READ_SECURE_REG_CMD, 8'h0}, 1, 0);
		cmp(host.rx[7:0], 8'h01 << LOCKDOWN_BIT);
		x(48, {WRITE_CONFIG_TWO_CMD, 32'h1, 8'h5E}, 1, 0);
		cmp(config_two_o[15:8], 8'h5E);
		x(48, {READ_CONFIG_TWO_CMD, 32'h1, 8'h0}, 1, 0);
		cmp(host.rx[7:0], 8'h5E);
		x(40, {WRITE_CONFIG_TWO_CMD, 32'h1}, 0, 1);
		$display("registers done");
	endtask
	task automatic t_prot;
		x(40, {PROGRAM_PERSISTENT_BIT_CMD, 32'h2_0000}, 1, 0);
		x(48, {READ_PERSISTENT_BIT_CMD, 32'h2_0000, 8'h0}, 1, 0);
		cmp({persistent_block_bit_o, host.rx[7:0]}, {16'h0004, BIT_SET_BYTE});
		x(8, ERASE_PERSISTENT_BITS_CMD, 1, 0);
		cmp(persistent_block_bit_o, 16'h0);
		x(48, {WRITE_DYNAMIC_BIT_CMD, 32'h3_0000, 8'h01}, 1, 0);
		x(48, {READ_DYNAMIC_BIT_CMD, 32'h3_0000, 8'h0}, 1, 0);
		cmp({dynamic_block_bit_o, host.rx[7:0]}, {16'h0008, BIT_SET_BYTE});
		x(8, PROTECT_SELECT_CMD, 1, 0);
		x(8, GANG_UNLOCK_CMD, 1, 0);
		cmp({block_mode_o, dynamic_block_bit_o}, 17'h1_0000);
		x(8, GANG_LOCK_CMD, 1, 0);
		cmp(dynamic_block_bit_o, 16'hFFFF);
		$display("protection done");
	endtask
	task automatic t_pass;
		x(48, {WRITE_PASSWORD_CMD, 32'h0, 8'h5A}, 1, 0);
		x(56, {READ_PASSWORD_CMD, 48'h0}, 1, 0);
		cmp(host.rx[7:0], 8'h5A);
		x(48, {PASSWORD_UNLOCK_CMD, 40'h0}, 1, 0);
		cmp(password_ok_o, 1'b0);
		x(48, {PASSWORD_UNLOCK_CMD, 32'h0, 8'h5A}, 1, 0);
		cmp(password_ok_o, 1'b1);
		$display("password done");
	endtask
	task automatic t_mreset;
		nm = 0;
		x(8, RESET_ARM_CMD, 1, 0);
		x(16, {READ_STATUS_CMD, 8'h0}, 1, 0);
		x(8, MEMORY_RESET_CMD, 1, 0);
		cmp({nm, password_ok_o}, 33'h1);
		x(8, RESET_ARM_CMD, 1, 0);
		x(8, MEMORY_RESET_CMD, -1, 0);
		cmp({nm, password_ok_o, dynamic_block_bit_o}, 49'h2_0000);
		x(16, {8'hC3, 8'h0}, 0, 1);
		x(4, 4'hF, 0, 0);
		cmp({status_o, config_o, lock_reg_o}, 24'h11A396);
		$display("memory reset done");
	endtask
	initial begin
		arst_n_i = 1'b0;
		rst;
		t_reset;
		t_ident;
		t_status;
		t_regs;
		t_prot;
		t_pass;
		t_mreset;
		rst;
		t_reset;
		summarize;
	end
	initial begin
		#200000;
		fails++;
		summarize;
	end
endmodule // spi_register_command_decoder_tb_top
